// ### ppr_core.sv
// Parallel poll configure, unconfigure, poll and response logic with an APB slave.
// Assumes an outside source handshake takes command bytes (sent with ATN true) and
// an acceptor delivers received bytes; all GPIB lines are logic-true (1 = asserted).
`timescale 1ns/1ps

// Functional notes
// (R01) Configure byte is 011, enable, sense, select
// (R02) Enable flag zero responds, one disables response
// (R03) Drive line only when status equals sense
// (R04) Select value n means data line n+1
// (R05) Only the active controller runs polls
// (R06) Send listen address, configure, byte, unlisten
// (R07) Build byte: enable clear, sense, line minus one
// (R08) Poll result bit k-1 reflects line k
// (R09) Shared lines OR together on the bus
// (R10) Device mode: status flag follows service request
// (R11) Byte 6D drives line 6 when status set
// (R12) Outside controller configures unit in device mode
// (R13) Per-target unconfigure sends byte 70
// (R14) Global unconfigure sends command 15
// (R15) Controller may configure its own response
// (R16) Switch 1 off selects serial command mode
// (R17) Host and unit share identical serial framing
// (R18) ATN with EOI starts poll identify
// (R19) Hold response during identify, release after
module ppr_core
#(
  parameter int SW_W = 8
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration switches, read as levels
  input wire logic [SW_W-1:0] cfg_sw,
  // High while this unit is the active controller
  input wire logic cic,
  // Command bytes towards the source handshake
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // Bytes received by the acceptor
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_atn,
  input wire logic rx_listener,
  // Bus lines, logic-true
  input wire logic atn_in,
  input wire logic eoi_in,
  input wire logic [7:0] dio_in,
  output logic [7:0] dio_out,
  output logic [7:0] dio_oe,
  output logic atn_out,
  output logic atn_oe,
  output logic eoi_out,
  output logic eoi_oe,
  output logic srq_out,
  output logic srq_oe
);

  // Identify counter width, taken from the package since nothing is imported
  localparam int POLL_CNT_W = ppr_pkg::POLL_CNT_W;
  // Sequencer and held operands
  ppr_pkg::ppr_state_t state;
  logic [2:0] op_reg;             // Last accepted operation
  logic [4:0] adr_reg;            // Target primary address
  logic [3:0] line_reg;           // Requested line, 1 to 8 for configure
  logic sense_reg;                // Requested sense
  logic [7:0] built_byte;         // Enable byte built from line and sense
  logic [POLL_CNT_W-1:0] poll_cnt; // Identify hold counter
  logic [7:0] poll_result;        // Last poll response byte
  // Own response configuration
  logic resp_en;                  // Response enabled
  logic resp_sense;               // Sense to match
  logic [2:0] resp_sel;           // Line select value
  logic ppc_pending;              // Configure command seen while listening
  // Individual status
  logic ist_sw;                   // Software status, serial mode
  logic srq_req;                  // Service request, device mode
  logic ist;
  logic serial_mode;
  logic identify;
  // Bus access decode
  logic wr_en;
  logic rd_en;
  logic hit_cmd;
  logic hit_stat;
  logic hit_ist;
  logic cmd_bad;
  logic [2:0] wr_op;
  logic [3:0] wr_line;

  // Switch 1 off means serial command mode; other switches carry framing only
  assign serial_mode = ~cfg_sw[ppr_pkg::SW_MODE_BIT]; // R16
  // In device mode the status flag is the service request itself
  assign ist = serial_mode ? ist_sw : srq_req; // R10
  // Poll identify is ATN together with EOI
  assign identify = atn_in & eoi_in; // R18

  // APB access phase; the slave never inserts wait states
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign hit_cmd = (paddr == ppr_pkg::CMD_ADDR);
  assign hit_stat = (paddr == ppr_pkg::STAT_ADDR);
  assign hit_ist = (paddr == ppr_pkg::IST_ADDR);
  assign wr_op = pwdata[ppr_pkg::CMD_OP_LSB +: ppr_pkg::CMD_OP_W];
  assign wr_line = pwdata[ppr_pkg::CMD_LINE_LSB +: ppr_pkg::CMD_LINE_W];

  // A command is refused while busy, with a bad line, unknown, or a bus operation (configure, unconfigure, poll) without control
  always_comb
  begin
    cmd_bad = (state != ppr_pkg::ST_IDLE);
    case (wr_op)
      ppr_pkg::OP_CONFIGURE,
      ppr_pkg::OP_SELF_CFG:
        cmd_bad = cmd_bad | (wr_line == 4'h0) | (wr_line > ppr_pkg::LINE_MAX);
      ppr_pkg::OP_UNCFG_ONE,
      ppr_pkg::OP_UNCFG_ALL:
        cmd_bad = cmd_bad | ~cic;
      ppr_pkg::OP_POLL:
        cmd_bad = cmd_bad | ~cic; // R05
      default:
        cmd_bad = 1'b1;
    endcase
    // Self configure needs no bus, so control is not required for it
    if ((wr_op == ppr_pkg::OP_CONFIGURE) && !cic)
    begin
      cmd_bad = 1'b1;
    end
  end

  // Error answer: unmapped address, write to the status register, refused command
  always_comb
  begin
    pslverr = 1'b0;
    if (psel && penable)
    begin
      if (!(hit_cmd || hit_stat || hit_ist))
      begin
        pslverr = 1'b1;
      end
      else if (pwrite && hit_stat)
      begin
        pslverr = 1'b1;
      end
      else if (pwrite && hit_cmd && cmd_bad)
      begin
        pslverr = 1'b1;
      end
    end
  end

  // Read data; unmapped reads return zero
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd_en && hit_cmd)
    begin
      prdata[ppr_pkg::CMD_OP_LSB +: ppr_pkg::CMD_OP_W] = op_reg;
      prdata[ppr_pkg::CMD_ADR_LSB +: ppr_pkg::CMD_ADR_W] = adr_reg;
      prdata[ppr_pkg::CMD_LINE_LSB +: ppr_pkg::CMD_LINE_W] = line_reg;
      prdata[ppr_pkg::CMD_SENSE_BIT] = sense_reg;
    end
    else if (rd_en && hit_stat)
    begin
      prdata[ppr_pkg::ST_BUSY_BIT] = (state != ppr_pkg::ST_IDLE);
      prdata[ppr_pkg::ST_EN_BIT] = resp_en;
      prdata[ppr_pkg::ST_SENSE_BIT] = resp_sense;
      prdata[ppr_pkg::ST_SEL_LSB +: 3] = resp_sel;
      prdata[ppr_pkg::ST_IST_BIT] = ist;
      prdata[ppr_pkg::ST_SMODE_BIT] = serial_mode;
      // Framing switches are shown so software can match the host side
      prdata[ppr_pkg::ST_SW_LSB +: SW_W] = cfg_sw; // R17
      prdata[ppr_pkg::ST_RESULT_LSB +: 8] = poll_result;
      prdata[ppr_pkg::ST_CIC_BIT] = cic;
    end
    else if (rd_en && hit_ist)
    begin
      prdata[ppr_pkg::IST_SW_BIT] = ist_sw;
      prdata[ppr_pkg::IST_SRQ_BIT] = srq_req;
    end
  end

  // Enable byte: 011, enable flag clear, sense, line minus one
  always_comb
  begin
    built_byte = {ppr_pkg::PPE_TOP, 1'b0, sense_reg, 3'(line_reg - 4'h1)}; // R07 R01 R04
  end

  // Operands captured on an accepted command write
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      op_reg <= 3'h0;
      adr_reg <= 5'h00;
      line_reg <= 4'h1;
      sense_reg <= 1'b0;
    end
    else if (wr_en && hit_cmd && !cmd_bad)
    begin
      op_reg <= wr_op;
      adr_reg <= pwdata[ppr_pkg::CMD_ADR_LSB +: ppr_pkg::CMD_ADR_W];
      line_reg <= wr_line;
      sense_reg <= pwdata[ppr_pkg::CMD_SENSE_BIT];
    end
  end

  // Individual status sources written by software
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ist_sw <= 1'b0;
      srq_req <= 1'b0;
    end
    else if (wr_en && hit_ist)
    begin
      ist_sw <= pwdata[ppr_pkg::IST_SW_BIT];
      srq_req <= pwdata[ppr_pkg::IST_SRQ_BIT];
    end
  end

  // Service request pin follows the request only in device mode
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      srq_oe <= 1'b0;
    end
    else
    begin
      srq_oe <= srq_req & ~serial_mode; // R10
    end
  end
  assign srq_out = srq_oe;

  // Controller sequencer: configure, unconfigure and poll
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ppr_pkg::ST_IDLE;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      poll_cnt <= '0;
    end
    else
    begin
      case (state)
        ppr_pkg::ST_IDLE:
        begin
          if (wr_en && hit_cmd && !cmd_bad)
          begin
            case (wr_op)
              ppr_pkg::OP_CONFIGURE,
              ppr_pkg::OP_UNCFG_ONE:
              begin
                // Address the target as listener first
                tx_data <= ppr_pkg::LAG_BASE | {3'h0, pwdata[ppr_pkg::CMD_ADR_LSB +: ppr_pkg::CMD_ADR_W]}; // R06
                tx_valid <= 1'b1;
                state <= ppr_pkg::ST_LAG;
              end
              ppr_pkg::OP_UNCFG_ALL:
              begin
                tx_data <= ppr_pkg::CMD_PPU; // R14
                tx_valid <= 1'b1;
                state <= ppr_pkg::ST_PPU;
              end
              ppr_pkg::OP_POLL:
              begin
                poll_cnt <= POLL_CNT_W'(ppr_pkg::POLL_CYCLES - 1);
                state <= ppr_pkg::ST_POLL; // R05
              end
              default:
                state <= ppr_pkg::ST_IDLE;
            endcase
          end
        end
        ppr_pkg::ST_LAG:
        begin
          if (tx_ready)
          begin
            tx_data <= ppr_pkg::CMD_PPC; // R06
            state <= ppr_pkg::ST_PPC;
          end
        end
        ppr_pkg::ST_PPC:
        begin
          if (tx_ready)
          begin
            // Unconfigure of one target sends the disable byte instead
            tx_data <= (op_reg == ppr_pkg::OP_UNCFG_ONE) ? ppr_pkg::PPD_BYTE : built_byte; // R13 R06
            state <= ppr_pkg::ST_PPE;
          end
        end
        ppr_pkg::ST_PPE:
        begin
          if (tx_ready)
          begin
            tx_data <= ppr_pkg::CMD_UNL; // R06
            state <= ppr_pkg::ST_UNL;
          end
        end
        ppr_pkg::ST_UNL,
        ppr_pkg::ST_PPU:
        begin
          if (tx_ready)
          begin
            tx_valid <= 1'b0;
            state <= ppr_pkg::ST_IDLE;
          end
        end
        ppr_pkg::ST_POLL:
        begin
          if (poll_cnt == '0)
          begin
            state <= ppr_pkg::ST_IDLE;
          end
          else
          begin
            poll_cnt <= poll_cnt - 1'b1;
          end
        end
        default:
        begin
          state <= ppr_pkg::ST_IDLE;
          tx_valid <= 1'b0;
        end
      endcase
    end
  end

  // ATN and EOI driven together for the whole identify window
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      atn_oe <= 1'b0;
      eoi_oe <= 1'b0;
    end
    else
    begin
      atn_oe <= (state == ppr_pkg::ST_POLL) && (poll_cnt != '0); // R18
      eoi_oe <= (state == ppr_pkg::ST_POLL) && (poll_cnt != '0); // R18
    end
  end
  assign atn_out = atn_oe;
  assign eoi_out = eoi_oe;

  // Response byte sampled at the end of the identify window; lines are wired-OR
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      poll_result <= 8'h00;
    end
    else if (state == ppr_pkg::ST_POLL && poll_cnt == POLL_CNT_W'(1))
    begin
      poll_result <= dio_in; // R08 R09
    end
  end

  // Own response configuration from received commands or from self configure
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      resp_en <= 1'b0;
      resp_sense <= 1'b0;
      resp_sel <= 3'h0;
      ppc_pending <= 1'b0;
    end
    else if (wr_en && hit_cmd && !cmd_bad && wr_op == ppr_pkg::OP_SELF_CFG)
    begin
      // Controller configures itself without using the bus
      resp_en <= 1'b1; // R15
      resp_sense <= pwdata[ppr_pkg::CMD_SENSE_BIT];
      resp_sel <= 3'(wr_line - 4'h1); // R04
      ppc_pending <= 1'b0;
    end
    else if (rx_valid && rx_atn)
    begin
      ppc_pending <= 1'b0;
      if (rx_data == ppr_pkg::CMD_PPU)
      begin
        resp_en <= 1'b0; // R14
      end
      else if (ppc_pending && rx_data >= ppr_pkg::PPE_MIN && rx_data <= ppr_pkg::PPE_MAX)
      begin
        // Enable flag zero: respond with the carried sense and line
        resp_en <= ~rx_data[ppr_pkg::PPE_U_BIT]; // R02 R01 R12
        resp_sense <= rx_data[ppr_pkg::PPE_S_BIT]; // R03
        resp_sel <= rx_data[2:0]; // R04 R11
      end
      else if (ppc_pending && rx_data >= ppr_pkg::PPD_MIN && rx_data <= ppr_pkg::PPD_MAX)
      begin
        resp_en <= 1'b0; // R02 R13
      end
      else if (rx_data == ppr_pkg::CMD_PPC && rx_listener)
      begin
        ppc_pending <= 1'b1;
      end
    end
  end

  // Response drive: held while identify lasts, dropped the edge after it ends
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dio_oe <= 8'h00;
    end
    else if (identify && resp_en && (ist == resp_sense))
    begin
      dio_oe <= 8'h01 << resp_sel; // R03 R19 R11
    end
    else
    begin
      dio_oe <= 8'h00; // R19
    end
  end
  assign dio_out = dio_oe;

endmodule

// ### ppr_pkg.sv
// Constants for the parallel poll configure and response block.
// Assumes a 32-bit APB slave port and GPIB lines carried as logic-true levels.
package ppr_pkg;
  // Register byte addresses
  localparam logic [7:0] CMD_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam logic [7:0] IST_ADDR = 8'h08;
  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 3;
  localparam int CMD_ADR_LSB = 4;
  localparam int CMD_ADR_W = 5;
  localparam int CMD_LINE_LSB = 12;
  localparam int CMD_LINE_W = 4;
  localparam int CMD_SENSE_BIT = 16;
  // Status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_EN_BIT = 1;
  localparam int ST_SENSE_BIT = 2;
  localparam int ST_SEL_LSB = 3;
  localparam int ST_IST_BIT = 6;
  localparam int ST_SMODE_BIT = 7;
  localparam int ST_SW_LSB = 8;
  localparam int ST_RESULT_LSB = 16;
  localparam int ST_CIC_BIT = 24;
  // Individual status register fields
  localparam int IST_SW_BIT = 0;
  localparam int IST_SRQ_BIT = 1;
  // Operations started through the command register
  typedef enum logic [2:0]
  {
    OP_CONFIGURE = 3'h0,
    OP_UNCFG_ONE = 3'h1,
    OP_UNCFG_ALL = 3'h2,
    OP_SELF_CFG = 3'h3,
    OP_POLL = 3'h4
  } ppr_op_t;
  // Configure byte layout: 011 U S D2 D1 D0
  localparam logic [2:0] PPE_TOP = 3'h3;
  localparam int PPE_U_BIT = 4;
  localparam int PPE_S_BIT = 3;
  localparam logic [7:0] PPE_MIN = 8'h60;
  localparam logic [7:0] PPE_MAX = 8'h6f;
  localparam logic [7:0] PPD_MIN = 8'h70;
  localparam logic [7:0] PPD_MAX = 8'h7f;
  localparam logic [7:0] PPD_BYTE = 8'h70;
  // Bus commands
  localparam logic [7:0] CMD_PPC = 8'h05;
  localparam logic [7:0] CMD_PPU = 8'h15;
  localparam logic [7:0] CMD_UNL = 8'h3f;
  localparam logic [7:0] LAG_BASE = 8'h20;
  localparam logic [3:0] LINE_MAX = 4'h8;
  // Switch 1 is bit 0; off selects serial command mode
  localparam int SW_MODE_BIT = 0;
  // Poll identify hold time
  localparam int CLK_PERIOD_NS = 100;
  localparam int POLL_TIME_NS = 2000;
  localparam int POLL_CYCLES = (POLL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POLL_CNT_W = 8;
  // Sequencer states
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_LAG,
    ST_PPC,
    ST_PPE,
    ST_UNL,
    ST_PPU,
    ST_POLL
  } ppr_state_t;
endpackage

// ### ppr_core_asserts.sv
// Concurrent checks on the ports of ppr_core.
// Assumes it is bound into ppr_core and sees only that module's ports.
`timescale 1ns/1ps
module ppr_chk
#(
  parameter int SW_W = 8
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cic,
  input wire logic [SW_W-1:0] cfg_sw,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic atn_in,
  input wire logic eoi_in,
  input wire logic [7:0] dio_oe,
  input wire logic atn_oe,
  input wire logic eoi_oe,
  input wire logic srq_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Byte handed over by the source handshake
  wire logic take = tx_valid && tx_ready;
  // Identify window: only under control, both lines, fixed length
  chk_poll_cic: assert property ($rose(atn_oe) |-> $past(cic))
    else $error("poll started without control");
  chk_poll_pair: assert property (atn_oe == eoi_oe)
    else $error("attention and identify differ");
  chk_poll_len: assert property ($rose(atn_oe) |-> atn_oe[*8] ##1 atn_oe[*8] ##1 atn_oe[*3] ##1 !atn_oe)
    else $error("identify window length wrong");
  // Response: one line, caused by identify, dropped one edge after it
  chk_resp_line: assert property ($onehot0(dio_oe))
    else $error("more than one response line");
  chk_resp_cause: assert property (dio_oe != 8'h00 |-> $past(atn_in && eoi_in))
    else $error("response without identify");
  chk_resp_drop: assert property (!(atn_in && eoi_in) |=> dio_oe == 8'h00)
    else $error("response held after identify");
  // Service request only in bus-device mode
  chk_srq_mode: assert property (srq_oe |-> $past(cfg_sw[ppr_pkg::SW_MODE_BIT]))
    else $error("service request outside device mode");
  // Configure sequence order
  chk_seq_ppc: assert property (take && tx_data inside {[8'h20:8'h3e]} |=> tx_valid && tx_data == ppr_pkg::CMD_PPC)
    else $error("configure command missing");
  chk_seq_ppe: assert property (take && tx_data == ppr_pkg::CMD_PPC |=> tx_valid && tx_data inside {[8'h60:8'h70]})
    else $error("enable byte missing");
  chk_seq_unl: assert property (take && tx_data inside {[8'h60:8'h70]} |=> tx_valid && tx_data == ppr_pkg::CMD_UNL)
    else $error("unlisten missing");
  chk_seq_ppu: assert property (take && tx_data == ppr_pkg::CMD_PPU |=> !tx_valid)
    else $error("bytes after global unconfigure");
  chk_seq_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte changed before taken");
endmodule

bind ppr_core ppr_chk #(.SW_W(SW_W)) u_chk (.core_clk, .rst_b, .cic, .cfg_sw, .tx_data, .tx_valid,
  .tx_ready, .atn_in, .eoi_in, .dio_oe, .atn_oe, .eoi_oe, .srq_oe);

// ### ppr_bus_model.sv
// Behavioural remote bus device: accepts command bytes and answers polls.
// Assumes logic-true lines; released lines read false through the bus pull-ups.
`timescale 1ns/1ps
module ppr_bus_model
#(
  parameter logic [4:0] ADR = 5'h05
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic slow,
  input wire logic idy,
  input wire logic ist,
  output logic [7:0] resp
);
  logic [7:0] log_q[$]; // Bytes taken, read by the bench
  logic lsn, arm, en, sns; // Addressed, armed, enabled, sense
  logic [2:0] sel; // Response line minus one
  wire logic take = tx_valid && tx_ready;
  // Acceptor pacing; slow mode stalls every other cycle
  always @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      tx_ready <= 1'b0;
    else
      tx_ready <= slow ? !tx_ready : 1'b1;
  // Command decode; any byte other than the configure command disarms
  always @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      lsn <= 1'b0;
      arm <= 1'b0;
      en <= 1'b0;
    end
    else if (take)
    begin
      log_q.push_back(tx_data);
      arm <= 1'b0;
      if (tx_data == 8'h3f)
        lsn <= 1'b0;
      else if (tx_data[7:5] == 3'h1)
        lsn <= tx_data[4:0] == ADR;
      else if (tx_data == 8'h15)
        en <= 1'b0;
      else if (tx_data == 8'h05)
        arm <= lsn;
      else if (arm && tx_data[7:5] == 3'h3)
      begin
        en <= !tx_data[4];
        sns <= tx_data[3];
        sel <= tx_data[2:0];
      end
    end
  // Answer on line sel+1 only while identify holds and status matches sense
  assign resp = (idy && en && ist == sns) ? 8'h01 << sel : 8'h00;
endmodule

// ### tb_top.sv
// Self-checking bench for ppr_core with one remote device on the bus.
// Assumes ppr_pkg, ppr_core, the checker and the bus model compile first.
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [4:0] adr; logic [3:0] ln; logic s; logic slw; logic [7:0] ppe; logic [7:0] res;} ppr_row_t;
  logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = '0, cfg_sw = 8'h5a, rx_data = '0, tx_data, dio_out, dio_oe, resp;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, err, tx_valid, tx_ready, atn_out, atn_oe, eoi_out, eoi_oe, srq_out, srq_oe;
  logic cic = 1'b1, slow = 1'b0, idy_x = 1'b0, r_ist = 1'b0;
  logic rx_valid = 1'b0, rx_atn = 1'b0, rx_listener = 1'b0;
  int error_cnt = 0, checks = 0;
  // Bus lines: responses OR together, identify from either controller
  wire logic atn_in = atn_out | idy_x;
  wire logic eoi_in = eoi_out | idy_x;
  wire logic [7:0] dio_in = dio_out | resp;
  // Configure rows: target, line, sense, slow acceptor, byte, poll result
  ppr_row_t rows [4] = '{'{5'h05, 4'h3, 1'b1, 1'b0, 8'h6a, 8'h04}, '{5'h06, 4'h4, 1'b0, 1'b1, 8'h63, 8'h00},
    '{5'h05, 4'h1, 1'b1, 1'b0, 8'h68, 8'h01}, '{5'h05, 4'h8, 1'b0, 1'b1, 8'h67, 8'h80}};
  ppr_core dut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cfg_sw, .cic, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_atn, .rx_listener, .atn_in,
    .eoi_in, .dio_in, .dio_out, .dio_oe, .atn_out, .atn_oe, .eoi_out, .eoi_oe, .srq_out, .srq_oe);
  ppr_bus_model bm (.core_clk, .rst_b, .tx_data, .tx_valid, .tx_ready, .slow, .idy(atn_in && eoi_in),
    .ist(r_ist), .resp);
  // Free-running core clock
  initial
    forever #50 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // One APB transfer; holds the request until pready, then idles an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Wait ends at the first edge with pready high
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic cmd(input ppr_pkg::ppr_op_t op, input logic [4:0] a, input logic [3:0] ln, input logic s);
    apb(1'b1, ppr_pkg::CMD_ADDR, {15'h0000, s, ln, 3'h0, a, 1'b0, op});
  endtask
  // Status polled until not busy; bounded
  task automatic idle();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, ppr_pkg::STAT_ADDR, '0);
      n++;
    end
    while (rdat[ppr_pkg::ST_BUSY_BIT] !== 1'b0 && n < 60);
    chk(rdat[ppr_pkg::ST_BUSY_BIT], 1'b0, "busy timeout");
  endtask
  task automatic poll();
    cmd(ppr_pkg::OP_POLL, 5'h00, 4'h0, 1'b0);
    idle();
  endtask
  // Bytes taken by the remote device, first byte in the top of e
  task automatic seq(input logic [31:0] e, input int n);
    chk(bm.log_q.size(), n, "byte count");
    for (int i = 0; i < n && i < bm.log_q.size(); i++)
      chk(bm.log_q[i], e[31-8*i -: 8], "sequence byte");
    bm.log_q.delete();
  endtask
  // Outside controller sends one command byte
  task automatic rx(input logic [7:0] b);
    rx_data <= b;
    rx_atn <= 1'b1;
    rx_valid <= 1'b1;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic conclude();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial
  begin
    #3000000;
    error_cnt++;
    conclude();
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, ppr_pkg::STAT_ADDR, '0);
    chk(rdat, {7'h00, cic, 8'h00, cfg_sw, ~cfg_sw[0], 7'h00}, "status after reset");
    apb(1'b0, ppr_pkg::IST_ADDR, '0);
    chk(rdat, 32'h0, "ist after reset");
    foreach (rows[i])
    begin
      slow <= rows[i].slw;
      cmd(ppr_pkg::OP_CONFIGURE, rows[i].adr, rows[i].ln, rows[i].s);
      idle();
      seq({3'h1, rows[i].adr, ppr_pkg::CMD_PPC, rows[i].ppe, ppr_pkg::CMD_UNL}, 4);
      r_ist <= rows[i].s;
      poll();
      chk(rdat[23:16], rows[i].res, "poll result");
    end
    r_ist <= 1'b1;
    poll();
    chk(rdat[23:16], 8'h00, "status differs from sense");
    // Controller answers its own poll on a line shared with the target
    r_ist <= 1'b0;
    cmd(ppr_pkg::OP_SELF_CFG, 5'h00, 4'h8, 1'b1);
    apb(1'b1, ppr_pkg::IST_ADDR, 32'h1);
    apb(1'b0, ppr_pkg::STAT_ADDR, '0);
    chk(rdat[6:1], 6'h3f, "self configure");
    poll();
    chk(rdat[23:16], 8'h80, "both on line 8");
    r_ist <= 1'b1;
    poll();
    chk(rdat[23:16], 8'h80, "controller alone");
    apb(1'b1, ppr_pkg::IST_ADDR, '0);
    r_ist <= 1'b0;
    cmd(ppr_pkg::OP_UNCFG_ONE, 5'h05, 4'h0, 1'b0);
    idle();
    seq(32'h2505703f, 4);
    poll();
    chk(rdat[23:16], 8'h00, "target disabled");
    cmd(ppr_pkg::OP_CONFIGURE, 5'h05, 4'h2, 1'b0);
    idle();
    seq(32'h2505613f, 4);
    cmd(ppr_pkg::OP_UNCFG_ALL, 5'h00, 4'h0, 1'b0);
    idle();
    seq(32'h15000000, 1);
    poll();
    chk(rdat[23:16], 8'h00, "all disabled");
    // Refusals: a command while busy, then requests without control
    cmd(ppr_pkg::OP_POLL, 5'h00, 4'h0, 1'b0);
    cmd(ppr_pkg::OP_SELF_CFG, 5'h00, 4'h1, 1'b0);
    chk(err, 1'b1, "command while busy");
    idle();
    cic <= 1'b0;
    apb(1'b1, ppr_pkg::CMD_ADDR, {29'h0, ppr_pkg::OP_POLL});
    chk(err, 1'b1, "poll without control");
    repeat (2) @(posedge core_clk);
    chk(atn_oe, 1'b0, "identify without control");
    apb(1'b0, 8'h0c, '0);
    chk(err, 1'b1, "unmapped address");
    apb(1'b1, ppr_pkg::STAT_ADDR, '0);
    chk(err, 1'b1, "status write");
    cmd(ppr_pkg::OP_SELF_CFG, 5'h00, 4'h0, 1'b0);
    chk(err, 1'b1, "line zero");
    cmd(ppr_pkg::OP_SELF_CFG, 5'h00, 4'h9, 1'b0);
    chk(err, 1'b1, "line nine");
    apb(1'b1, ppr_pkg::CMD_ADDR, 32'h0000_0005);
    chk(err, 1'b1, "unknown operation");
    apb(1'b0, ppr_pkg::STAT_ADDR, '0);
    chk(rdat[5:1], 5'h1f, "refused writes kept state");
    // Bus-device mode, configured by an outside controller
    cfg_sw <= 8'h01;
    rx_listener <= 1'b1;
    rx(ppr_pkg::CMD_PPC);
    rx(8'h6d);
    apb(1'b1, ppr_pkg::IST_ADDR, 32'h2);
    apb(1'b0, ppr_pkg::STAT_ADDR, '0);
    chk({rdat[7:6], srq_oe}, 3'h3, "device mode request");
    idy_x <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({dio_oe, dio_in}, 16'h2020, "line 6 response");
    idy_x <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(dio_oe, 8'h00, "released after identify");
    apb(1'b1, ppr_pkg::IST_ADDR, '0);
    idy_x <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({dio_oe, srq_oe}, 9'h000, "no request no response");
    idy_x <= 1'b0;
    // Enable flag set in a received byte stops the response
    apb(1'b1, ppr_pkg::IST_ADDR, 32'h2);
    rx(ppr_pkg::CMD_PPC);
    rx(8'h7d);
    idy_x <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(dio_oe, 8'h00, "disabled by enable flag");
    idy_x <= 1'b0;
    conclude();
  end
endmodule
